// *** hdl/buck_ctrl_defs.vh ***
// constants for the step-down converter switching controller
// assumes a 50 MHz control clock; oscillator cycle is derived from it
`ifndef BUCK_CTRL_DEFS_VH
`define BUCK_CTRL_DEFS_VH

`define CLK_FREQ_HZ 50000000
`define OSC_FREQ_HZ 2000000
// cycles per oscillator period (2 MHz from 50 MHz, rounded down)
`define OSC_PERIOD_CYC (`CLK_FREQ_HZ / `OSC_FREQ_HZ)
`define OSC_CNT_W 5
// oscillator cycles of a persisting light-load condition before skip entry
`define SKIP_ENTRY_CYCLES 32
`define ENTRY_CNT_W 6
// oscillator cycles spent on each soft-start current-limit step
`define SOFT_STEP_CYCLES 64
`define STEP_CNT_W 7
// the same counts as terminal values, sized to their counters
`define OSC_LAST_CNT 5'h18
`define ENTRY_LIMIT 6'h20
`define STEP_LAST_CNT 7'h3f
// current-limit select codes, 70/140/280/1020 mA
`define ILIM_SEL_70MA 2'h0
`define ILIM_SEL_140MA 2'h1
`define ILIM_SEL_280MA 2'h2
`define ILIM_SEL_FULL 2'h3
// operating states
`define MODE_SHUTDOWN 2'h0
`define MODE_PWM 2'h1
`define MODE_SKIP 2'h2
// pwm and skip cycle phases
`define PH_IDLE 3'h0
`define PH_HIGH 3'h1
`define PH_LOW 3'h2
`define PH_LIMIT 3'h3
`define PH_SKIP_HIGH 3'h4
`define PH_SKIP_LOW 3'h5
`define PH_SLEEP 3'h6

`endif

// *** hdl/sync_flag.v ***
// registered sampling of one analog indication
// assumes the indication is already synchronous to clk
`timescale 1ns/1ps
module sync_flag (
    input wire clk,     // control clock
    input wire srst,    // sync reset, active high
    input wire d,       // raw indication
    output reg q        // sampled indication
);
    always @(posedge clk) begin
        if (srst) begin
            q <= 1'b0;
        end else begin
            q <= d;
        end
    end
endmodule

// *** hdl/buck_switch_mode_controller.v ***
// switching-control logic of a synchronous step-down converter
// assumes analog comparators and sensors are synchronous to clk
`timescale 1ns/1ps
`include "buck_ctrl_defs.vh"

// Contract
// [RL1] three states: pulse-width, pulse-skip, shutdown
// [RL2] pulse-width mode switches at constant frequency, varying high-side on-time
// [RL3] pulse-width mode turns high side on at every cycle start
// [RL4] high side off on regulation trip or earlier on peak-current trip
// [RL5] low side on after high side off; never both on
// [RL6] cycle boundary turns low side off and high side on
// [RL7] short detected: timed limit keeps low side on until low-current threshold
// [RL8] soft start only on enable rise after supply-good
// [RL9] soft start steps limit 70, 140, 280, then full 1020 mA
// [RL10] enter pulse-skip after 32 cycles of zero current or low peak
// [RL11] pulse-skip regulates between 0.6% and 1.7% above nominal
// [RL12] skip: high side on until high threshold or light-load peak trip
// [RL13] skip: low side after high side, off at zero current
// [RL14] skip: repeat pulse pairs while output below high threshold
// [RL15] at high threshold: low side to zero current, then sleep
// [RL16] below lower skip threshold: return to pulse-width mode
// [RL17] enable low turns everything off; other party holds it low below supply minimum
// [RL18] sample indications on clock; clear entry counter without entry condition
// [RL19] leave shutdown in pulse-width mode, switches off until first boundary
module buck_switch_mode_controller (
    input wire clk,              // control clock
    input wire srst,             // sync reset, active high
    input wire enable,           // converter enable pin
    input wire supply_good,      // supply above minimum level
    input wire reg_trip,         // regulation comparator trip
    input wire peak_trip,        // peak-current comparator at selected limit
    input wire zero_current,     // low-side current reached zero
    input wire below_mode_level, // high-side peak below mode-entry threshold
    input wire short_detect,     // output short detected
    input wire low_current,      // inductor current below low threshold
    input wire below_high_thr,   // output below upper skip threshold
    input wire below_lower_skip_exit_threshold, // output below lower skip threshold
    input wire light_load_peak_current, // skip-mode peak-current comparator trip
    output reg high_side_on,     // high-side switch drive
    output reg low_side_on,      // low-side switch drive
    output reg [1:0] ilim_sel,   // current-limit level select
    output reg skip_thr_en,      // select skip thresholds (0.6%/1.7% above nominal)
    output reg soft_start_active, // soft start in progress
    output reg [1:0] mode        // operating state
);
    localparam [`OSC_CNT_W-1:0] OSC_LAST = `OSC_LAST_CNT;
    localparam [`ENTRY_CNT_W-1:0] ENTRY_N = `ENTRY_LIMIT;
    localparam [`STEP_CNT_W-1:0] STEP_LAST = `STEP_LAST_CNT;

    wire [8:0] raw;
    wire [8:0] smp;
    wire reg_trip_s, peak_trip_s, zero_s, below_mode_s, short_s;
    wire low_cur_s, below_high_s, below_low_s, llpk_s;

    assign raw = {reg_trip, peak_trip, zero_current, below_mode_level, short_detect,
                  low_current, below_high_thr, below_lower_skip_exit_threshold,
                  light_load_peak_current};
    assign {reg_trip_s, peak_trip_s, zero_s, below_mode_s, short_s,
            low_cur_s, below_high_s, below_low_s, llpk_s} = smp;

    genvar gi;
    generate
        for (gi = 0; gi < 9; gi = gi + 1) begin : g_smp
            sync_flag u_smp ( // [RL18]
                .clk(clk),
                .srst(srst),
                .d(raw[gi]),
                .q(smp[gi])
            );
        end
    endgenerate

    reg [`OSC_CNT_W-1:0] osc_reg;
    reg [2:0] phase_reg;
    reg [2:0] phase_next;
    reg [`ENTRY_CNT_W-1:0] entry_cnt_reg;
    reg [`STEP_CNT_W-1:0] step_cnt_reg;
    reg enable_d_reg;
    reg zero_seen_reg;
    reg low_mode_seen_reg;
    wire boundary;
    wire en_rise;

    // oscillator boundary: start of each fixed-frequency cycle
    assign boundary = (osc_reg == OSC_LAST); // [RL2]
    assign en_rise = enable & ~enable_d_reg;

    always @(posedge clk) begin
        if (srst || !enable) begin
            osc_reg <= {`OSC_CNT_W{1'b0}};
        end else if (boundary) begin
            osc_reg <= {`OSC_CNT_W{1'b0}};
        end else begin
            osc_reg <= osc_reg + 1'b1;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            enable_d_reg <= 1'b0;
        end else begin
            enable_d_reg <= enable;
        end
    end

    // phase sequencing; next phase chosen combinationally
    always @* begin
        phase_next = phase_reg;
        case (phase_reg)
            `PH_IDLE: begin
                if (mode == `MODE_PWM && boundary) begin
                    phase_next = `PH_HIGH; // [RL19]
                end
            end
            `PH_HIGH: begin
                if (reg_trip_s || peak_trip_s) begin
                    phase_next = short_s ? `PH_LIMIT : `PH_LOW; // [RL4] [RL5] [RL7]
                end
            end
            `PH_LOW: begin
                if (boundary) begin
                    phase_next = `PH_HIGH; // [RL3] [RL6]
                end
            end
            `PH_LIMIT: begin
                // hold low side past the boundary so inductor current can decay
                if (low_cur_s) begin
                    phase_next = `PH_LOW; // [RL7]
                end
            end
            `PH_SKIP_HIGH: begin
                if (!below_high_s || llpk_s) begin
                    phase_next = `PH_SKIP_LOW; // [RL12]
                end
            end
            `PH_SKIP_LOW: begin
                if (zero_s) begin
                    // output still low: another pair, else sleep
                    phase_next = below_high_s ? `PH_SKIP_HIGH : `PH_SLEEP; // [RL13] [RL14] [RL15]
                end
            end
            `PH_SLEEP: begin
                if (below_high_s) begin
                    phase_next = `PH_SKIP_HIGH; // [RL14]
                end
            end
            default: begin
                phase_next = `PH_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (srst || !enable) begin
            phase_reg <= `PH_IDLE; // [RL17]
            mode <= `MODE_SHUTDOWN; // [RL1]
            entry_cnt_reg <= {`ENTRY_CNT_W{1'b0}};
            zero_seen_reg <= 1'b0;
            low_mode_seen_reg <= 1'b0;
        end else if (mode == `MODE_SHUTDOWN) begin
            mode <= `MODE_PWM; // [RL19]
            phase_reg <= `PH_IDLE;
        end else if (mode == `MODE_SKIP && below_low_s) begin
            mode <= `MODE_PWM; // [RL16]
            phase_reg <= `PH_LOW;
            entry_cnt_reg <= {`ENTRY_CNT_W{1'b0}};
        end else if (mode == `MODE_PWM && entry_cnt_reg >= ENTRY_N && !soft_start_active
                     && (phase_reg == `PH_LOW)) begin
            mode <= `MODE_SKIP; // [RL10]
            phase_reg <= `PH_SKIP_LOW;
            entry_cnt_reg <= {`ENTRY_CNT_W{1'b0}};
        end else begin
            phase_reg <= phase_next;
            if (mode == `MODE_PWM) begin
                // per-cycle record of the two entry conditions
                if (boundary) begin
                    // an indication on the boundary edge is kept for the next period
                    zero_seen_reg <= zero_s && (phase_reg == `PH_LOW);
                    low_mode_seen_reg <= below_mode_s && (phase_reg == `PH_HIGH);
                    if (zero_seen_reg || low_mode_seen_reg) begin
                        if (entry_cnt_reg < ENTRY_N) begin
                            entry_cnt_reg <= entry_cnt_reg + 1'b1; // [RL10]
                        end
                    end else begin
                        entry_cnt_reg <= {`ENTRY_CNT_W{1'b0}}; // [RL18]
                    end
                end else begin
                    if (zero_s && phase_reg == `PH_LOW) begin
                        zero_seen_reg <= 1'b1;
                    end
                    if (below_mode_s && phase_reg == `PH_HIGH) begin
                        low_mode_seen_reg <= 1'b1;
                    end
                end
            end
        end
    end

    // soft start: stepped limit, armed only by enable rising with supply good
    always @(posedge clk) begin
        if (srst || !enable) begin
            ilim_sel <= `ILIM_SEL_FULL;
            soft_start_active <= 1'b0;
            step_cnt_reg <= {`STEP_CNT_W{1'b0}};
        end else if (en_rise && supply_good) begin
            ilim_sel <= `ILIM_SEL_70MA; // [RL8] [RL9]
            soft_start_active <= 1'b1;
            step_cnt_reg <= {`STEP_CNT_W{1'b0}};
        end else if (soft_start_active && boundary) begin
            if (step_cnt_reg == STEP_LAST) begin
                step_cnt_reg <= {`STEP_CNT_W{1'b0}};
                ilim_sel <= ilim_sel + 1'b1; // [RL9]
                if (ilim_sel == `ILIM_SEL_280MA) begin
                    soft_start_active <= 1'b0;
                end
            end else begin
                step_cnt_reg <= step_cnt_reg + 1'b1;
            end
        end
    end

    // switch drives registered from the phase; never both on
    always @(posedge clk) begin
        if (srst || !enable) begin
            high_side_on <= 1'b0; // [RL17]
            low_side_on <= 1'b0;
            skip_thr_en <= 1'b0;
        end else begin
            high_side_on <= (phase_reg == `PH_HIGH) || (phase_reg == `PH_SKIP_HIGH); // [RL5]
            low_side_on <= (phase_reg == `PH_LOW) || (phase_reg == `PH_LIMIT)
                           || (phase_reg == `PH_SKIP_LOW);
            skip_thr_en <= (mode == `MODE_SKIP); // [RL11]
        end
    end
endmodule

// *** dv/buck_ctrl_monitor.sv ***
// checker of switch sequencing on the controller's ports
// assumes the design's default period and step counts
`timescale 1ns/1ps
`include "buck_ctrl_defs.vh"
module buck_ctrl_monitor (
    input wire clk, // clock
    input wire srst, // reset
    input wire enable, // enable
    input wire supply_good, // supply
    input wire reg_trip, // comp
    input wire peak_trip, // comp
    input wire zero_current, // comp
    input wire below_mode_level, // comp
    input wire high_side_on, // drive
    input wire low_side_on, // drive
    input wire [1:0] ilim_sel, // limit
    input wire soft_start_active, // state
    input wire [1:0] mode // state
);
    reg [9:0] gap_reg;
    reg [5:0] run_reg;
    reg seen_reg;
    wire cond;
    assign cond = (zero_current && low_side_on) || (below_mode_level && high_side_on);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // sentinel outside pwm, so no gap spans a mode change
    always @(posedge clk) begin
        if (srst || mode != `MODE_PWM) gap_reg <= 10'h3ff;
        else if ($rose(high_side_on)) gap_reg <= 10'h1;
        else if (gap_reg != 10'h3ff) gap_reg <= gap_reg + 10'h1;
    end
    // periods in a row, between high-side rises, that showed an entry condition
    always @(posedge clk) begin
        if (srst || mode != `MODE_PWM) begin
            run_reg <= 6'h0;
            seen_reg <= 1'b0;
        end else if ($rose(high_side_on)) begin
            seen_reg <= cond;
            run_reg <= !seen_reg ? 6'h0 : run_reg + {5'h0, run_reg != 6'h3f};
        end else if (cond) begin
            seen_reg <= 1'b1;
        end
    end
    property p_excl; !(high_side_on && low_side_on); endproperty
    a_excl: assert property (p_excl) else $error("both switches on");
    property p_off; !enable |=> !high_side_on && !low_side_on && mode == `MODE_SHUTDOWN
        && ilim_sel == `ILIM_SEL_FULL && !soft_start_active; endproperty
    a_off: assert property (p_off) else $error("not shut down");
    property p_ss; !enable ##1 (enable && supply_good) |-> ##[1:3] (mode == `MODE_PWM
        && soft_start_active && ilim_sel == `ILIM_SEL_70MA); endproperty
    a_ss: assert property (p_ss) else $error("no soft start");
    property p_step; $changed(ilim_sel) && $past(soft_start_active) && enable
        |-> ilim_sel == $past(ilim_sel) + 2'h1; endproperty
    a_step: assert property (p_step) else $error("bad limit step");
    // two periods of slack for sampling skew against the design's boundary grid
    property p_entry; $rose(mode == `MODE_SKIP)
        |-> $past(mode) == `MODE_PWM && run_reg >= 6'h1e; endproperty
    a_entry: assert property (p_entry) else $error("early skip entry");
    property p_period; $rose(high_side_on) && gap_reg != 10'h3ff
        |-> gap_reg % `OSC_PERIOD_CYC == 0; endproperty
    a_period: assert property (p_period) else $error("high side off grid");
    property p_trip; mode == `MODE_PWM && high_side_on && (reg_trip || peak_trip)
        |-> ##[1:5] !high_side_on; endproperty
    a_trip: assert property (p_trip) else $error("high side kept on");
    property p_zero; mode == `MODE_SKIP && low_side_on && zero_current
        |-> ##[1:5] !low_side_on; endproperty
    a_zero: assert property (p_zero) else $error("low side kept on");
endmodule
bind buck_switch_mode_controller buck_ctrl_monitor buck_ctrl_monitor_i (.clk(clk), .srst(srst),
    .enable(enable), .supply_good(supply_good), .reg_trip(reg_trip), .peak_trip(peak_trip),
    .zero_current(zero_current), .below_mode_level(below_mode_level),
    .high_side_on(high_side_on), .low_side_on(low_side_on),
    .ilim_sel(ilim_sel), .soft_start_active(soft_start_active), .mode(mode));

// *** dv/power_stage_model.sv ***
// behavioural power stage: inductor current ramp and its comparators
// assumes registered switch drives on clk; current in arbitrary units
`timescale 1ns/1ps
module power_stage_model (
    input wire clk, // clock
    input wire high_side_on, // drive
    input wire low_side_on, // drive
    input wire [4:0] on_time, // load demand
    input wire [5:0] peak_lvl, // limit level
    output wire reg_trip, // comp
    output wire peak_trip, // comp
    output wire zero_current, // comp
    output wire low_current, // comp
    output wire below_mode_level, // comp
    output wire light_pk // comp
);
    reg [5:0] cur_reg = 6'h0;
    reg [4:0] on_reg = 5'h0;
    always @(posedge clk) begin
        if (high_side_on && cur_reg < 6'h3d) cur_reg <= cur_reg + 6'h2;
        else if (low_side_on && cur_reg != 6'h0) cur_reg <= cur_reg - 6'h1;
        on_reg <= high_side_on ? on_reg + 5'h1 : 5'h0;
    end
    assign reg_trip = high_side_on && on_reg >= on_time;
    assign peak_trip = cur_reg >= peak_lvl;
    assign zero_current = cur_reg == 6'h0;
    assign low_current = cur_reg < 6'h4;
    assign below_mode_level = cur_reg < 6'h6;
    assign light_pk = cur_reg >= 6'hc;
endmodule

// *** dv/buck_switch_mode_controller_test.sv ***
// self-checking bench for the switching controller and a power stage model
// assumes a 50 MHz clock and the design's fixed period and step counts
`timescale 1ns/1ps
`include "buck_ctrl_defs.vh"
module buck_switch_mode_controller_test;
    reg clk = 1'b0, srst = 1'b1, enable = 1'b0, supply_good = 1'b0, short_detect = 1'b0;
    reg below_high_thr = 1'b0, below_lower = 1'b0;
    reg [4:0] on_time = 5'hc;
    reg [5:0] peak_lvl = 6'h3f;
    wire reg_trip, peak_trip, zero_current, low_current, below_mode_level, light_pk;
    wire high_side_on, low_side_on, skip_thr_en, soft_start_active;
    wire [1:0] ilim_sel, mode;
    int errors = 0, n_checks = 0, cyc = 0, g, w, g2, w2, k;
    buck_switch_mode_controller buck_switch_mode_controller_i (.clk(clk), .srst(srst),
        .enable(enable), .supply_good(supply_good), .reg_trip(reg_trip), .peak_trip(peak_trip),
        .zero_current(zero_current), .below_mode_level(below_mode_level),
        .short_detect(short_detect), .low_current(low_current), .below_high_thr(below_high_thr),
        .below_lower_skip_exit_threshold(below_lower), .light_load_peak_current(light_pk),
        .high_side_on(high_side_on), .low_side_on(low_side_on), .ilim_sel(ilim_sel),
        .skip_thr_en(skip_thr_en), .soft_start_active(soft_start_active), .mode(mode));
    power_stage_model power_stage_model_i (.clk(clk), .high_side_on(high_side_on),
        .low_side_on(low_side_on), .on_time(on_time), .peak_lvl(peak_lvl), .reg_trip(reg_trip),
        .peak_trip(peak_trip), .zero_current(zero_current), .low_current(low_current),
        .below_mode_level(below_mode_level), .light_pk(light_pk));
    initial forever #10 clk = ~clk;
    // whole run needs about 8000 clocks
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            wrap_up();
        end
    end
    task wrap_up;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task chk_ok(input logic c);
        n_checks++;
        if (c !== 1'b1) begin
            errors++;
            $display("ERROR %0t timing out of range", $time);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // low samples before the next pulse, then its width
    task pulse(input bit lo, output int gp, output int wd);
        gp = 0;
        wd = 0;
        while ((lo ? low_side_on : high_side_on) !== 1'b1 && gp < 400) begin
            @(negedge clk);
            gp++;
        end
        while ((lo ? low_side_on : high_side_on) === 1'b1 && wd < 400) begin
            @(negedge clk);
            wd++;
        end
    endtask
    function logic [1:0] exp_ilim(input int s);
        return s >= 3 ? `ILIM_SEL_FULL : 2'(s);
    endfunction
    initial begin
        void'($urandom(32'hcad7cd7c));
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        tick(2);
        chk({high_side_on, low_side_on, mode}, {2'h0, `MODE_SHUTDOWN});
        // supply good first: enable never leads it
        @(posedge clk) supply_good <= 1'b1;
        @(posedge clk) enable <= 1'b1;
        tick(2);
        chk({high_side_on, low_side_on, mode}, {2'h0, `MODE_PWM});
        for (k = 0; k < 4; k++) begin
            tick(k == 0 ? 800 : 1600);
            chk(ilim_sel, exp_ilim(k));
        end
        chk(soft_start_active, 1'b0);
        $display("soft start test done");
        for (k = 0; k < 4; k++) begin
            @(posedge clk) on_time <= 5'($urandom_range(14, 6));
            tick(1);
            repeat (2) pulse(0, g, w);
            pulse(0, g2, w2);
            chk(w + g2, `OSC_PERIOD_CYC);
            chk_ok(w > on_time && w < on_time + 6);
        end
        $display("pwm test done");
        @(posedge clk);
        short_detect <= 1'b1;
        on_time <= 5'h14;
        tick(1);
        repeat (2) pulse(1, g, w);
        chk_ok(w > `OSC_PERIOD_CYC);
        @(posedge clk) short_detect <= 1'b0;
        @(posedge clk) peak_lvl <= 6'h20;
        tick(1);
        repeat (2) pulse(0, g, w);
        chk_ok(w < 16);
        $display("limit test done");
        @(posedge clk);
        on_time <= 5'h2;
        peak_lvl <= 6'h3f;
        tick(700);
        chk(mode, `MODE_PWM);
        tick(300);
        chk({skip_thr_en, mode}, {1'b1, `MODE_SKIP});
        @(posedge clk) below_high_thr <= 1'b1;
        tick(1);
        pulse(0, g, w);
        pulse(0, g2, w2);
        chk_ok(w > 0 && w < 14 && g2 < 40);
        @(posedge clk) below_high_thr <= 1'b0;
        tick(120);
        chk({high_side_on, low_side_on, mode}, {2'h0, `MODE_SKIP});
        @(posedge clk);
        below_lower <= 1'b1;
        on_time <= 5'hc;
        tick(6);
        chk(mode, `MODE_PWM);
        @(posedge clk) below_lower <= 1'b0;
        $display("skip test done");
        @(posedge clk) enable <= 1'b0;
        tick(3);
        chk({high_side_on, low_side_on, ilim_sel, mode}, {4'h3, `MODE_SHUTDOWN});
        @(posedge clk) supply_good <= 1'b0;
        $display("shutdown test done");
        wrap_up();
    end
endmodule
